// file: design/flow_pkg.sv
`default_nettype none
package flow_pkg;

  // instruction kinds handled by this unit
  typedef enum logic [2:0] {
    OP_NONE                 = 3'h0,
    OP_SKIP_IF_IO_BIT_CLEAR = 3'h1,
    OP_SKIP_IF_IO_BIT_SET   = 3'h2,
    OP_BRANCH_IF_FLAG_SET   = 3'h3,
    OP_BRANCH_IF_FLAG_CLEAR = 3'h4,
    OP_BRANCH_IF_EQUAL      = 3'h5,
    OP_BRANCH_IF_NOT_EQUAL  = 3'h6
  } op_t;

  localparam int PC_WIDTH      = 16;
  localparam int OFFSET_WIDTH  = 7;
  localparam int ZERO_FLAG_POS = 1;

  localparam logic [PC_WIDTH-1:0] PC_RESET      = 16'h0000;
  localparam logic [PC_WIDTH-1:0] PC_STEP       = 16'h0001;
  localparam logic [PC_WIDTH-1:0] SKIP_ONE_WORD = 16'h0002;
  localparam logic [PC_WIDTH-1:0] SKIP_TWO_WORD = 16'h0003;

  localparam logic [1:0] CYCLES_FALSE    = 2'h1;
  localparam logic [1:0] CYCLES_BRANCH   = 2'h2;
  localparam logic [1:0] CYCLES_SKIP_ONE = 2'h2;
  localparam logic [1:0] CYCLES_SKIP_TWO = 2'h3;

  // one instruction handed to the unit
  typedef struct packed {
    op_t                     op;
    logic [2:0]              bit_sel;
    logic [OFFSET_WIDTH-1:0] offset;
    logic                    next_is_two_word;
  } instr_t;

  // outcome of one instruction
  typedef struct packed {
    logic                taken;
    logic [1:0]          cycles;
    logic [PC_WIDTH-1:0] pc;
  } result_t;

endpackage : flow_pkg
`default_nettype wire

// file: design/cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
module cond_eval (
  // selectors
  input  wire logic [2:0] sel_i,
  input  wire logic       want_one_i,
  // data
  input  wire logic [7:0] bits_i,
  // result
  output logic            hit_o
);
  always_comb begin
    hit_o = (bits_i[sel_i] == want_one_i);
  end
endmodule : cond_eval
`default_nettype wire

// file: design/conditional_skip_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - io-bit-clear skip advances pc by 2 or 3 when bit is 0; 1/2/3 cycles.
// - io-bit-set skip advances pc by 2 or 3 when bit is 1; 1/2/3 cycles.
// - flag-set branch loads pc+k+1 when status bit is 1; 1 or 2 cycles.
// - flag-clear branch loads pc+k+1 when status bit is 0; 1 or 2 cycles.
// - branch-if-equal goes to pc+k+1 only when zero flag is 1; 1 or 2 cycles.
// - branch-if-not-equal goes to pc+k+1 only when zero flag is 0; 1 or 2 cycles.
// - no instruction here changes any status flag.
module conditional_skip_branch_unit #(
  parameter int PC_W = flow_pkg::PC_WIDTH
) (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 clk_en_i,
  // instruction issue
  input  wire logic                 issue_i,
  input  wire flow_pkg::instr_t     instr_i,
  output logic                      ready_o,
  // operands
  input  wire logic [PC_W-1:0]      pc_i,
  input  wire logic [7:0]           io_reg_i,
  input  wire logic [7:0]           status_flags_register_i,
  // results
  output flow_pkg::result_t         result_o,
  output logic                      done_o,
  output logic [7:0]                status_flags_register_o
);
  // parameter checks at elaboration
  if (PC_W != flow_pkg::PC_WIDTH) begin : g_bad_pc_w
    $error("pc width must match package");
  end
  if (flow_pkg::OFFSET_WIDTH >= PC_W) begin : g_bad_offset_w
    $error("offset must be narrower than pc");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } state_t;

  state_t             state;
  state_t             next_state;
  logic [1:0]         wait_cnt;
  logic [1:0]         next_wait_cnt;
  flow_pkg::result_t  res;
  flow_pkg::result_t  next_res;
  logic               done;
  logic               next_done;

  logic       is_io;
  logic       want_one;
  logic [2:0] sel;
  logic [7:0] src;
  logic       hit;
  logic [PC_W-1:0] k_ext;
  logic [PC_W-1:0] fall_pc;
  logic [PC_W-1:0] skip_pc;
  logic [PC_W-1:0] branch_pc;
  logic [1:0]      skip_cycles;

  // targets of all three outcomes, picked later by the condition
  always_comb begin
    k_ext     = {{(PC_W-flow_pkg::OFFSET_WIDTH){instr_i.offset[flow_pkg::OFFSET_WIDTH-1]}}, instr_i.offset};
    fall_pc   = pc_i + flow_pkg::PC_STEP;
    branch_pc = pc_i + k_ext + flow_pkg::PC_STEP;
    if (instr_i.next_is_two_word) begin
      skip_pc     = pc_i + flow_pkg::SKIP_TWO_WORD;
      skip_cycles = flow_pkg::CYCLES_SKIP_TWO;
    end else begin
      skip_pc     = pc_i + flow_pkg::SKIP_ONE_WORD;
      skip_cycles = flow_pkg::CYCLES_SKIP_ONE;
    end
  end

  always_comb begin
    is_io    = (instr_i.op == flow_pkg::OP_SKIP_IF_IO_BIT_CLEAR) ||
               (instr_i.op == flow_pkg::OP_SKIP_IF_IO_BIT_SET);
    src      = is_io ? io_reg_i : status_flags_register_i;
    sel      = instr_i.bit_sel;
    want_one = 1'b0;
    case (instr_i.op)
      flow_pkg::OP_SKIP_IF_IO_BIT_CLEAR: want_one = 1'b0;
      flow_pkg::OP_SKIP_IF_IO_BIT_SET:   want_one = 1'b1;
      flow_pkg::OP_BRANCH_IF_FLAG_SET:   want_one = 1'b1;
      flow_pkg::OP_BRANCH_IF_FLAG_CLEAR: want_one = 1'b0;
      flow_pkg::OP_BRANCH_IF_EQUAL: begin
        sel      = 3'(flow_pkg::ZERO_FLAG_POS);
        want_one = 1'b1;
      end
      flow_pkg::OP_BRANCH_IF_NOT_EQUAL: begin
        sel      = 3'(flow_pkg::ZERO_FLAG_POS);
        want_one = 1'b0;
      end
      default: want_one = 1'b0;
    endcase
  end

  cond_eval u_cond (
    .sel_i      (sel),
    .want_one_i (want_one),
    .bits_i     (src),
    .hit_o      (hit)
  );

  always_comb begin
    next_state    = state;
    next_wait_cnt = wait_cnt;
    next_res      = res;
    next_done     = 1'b0;
    case (state)
      ST_IDLE: begin
        if (issue_i && instr_i.op != flow_pkg::OP_NONE) begin
          next_res.taken = hit;
          if (!hit) begin
            next_res.pc     = fall_pc;
            next_res.cycles = flow_pkg::CYCLES_FALSE;
          end else if (is_io) begin
            next_res.pc     = skip_pc;
            next_res.cycles = skip_cycles;
          end else begin
            next_res.pc     = branch_pc;
            next_res.cycles = flow_pkg::CYCLES_BRANCH;
          end
          next_wait_cnt = next_res.cycles - 2'h1;
          if (next_res.cycles == flow_pkg::CYCLES_FALSE) begin
            next_state = ST_DONE;
            next_done  = 1'b1;
          end else begin
            next_state = ST_BUSY;
          end
        end
      end
      ST_BUSY: begin
        next_wait_cnt = wait_cnt - 2'h1;
        if (wait_cnt == 2'h1) begin
          next_state = ST_DONE;
          next_done  = 1'b1;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      wait_cnt <= 2'h0;
      res      <= '{taken: 1'b0, cycles: 2'h0, pc: flow_pkg::PC_RESET};
      done     <= 1'b0;
    end else if (clk_en_i) begin
      state    <= next_state;
      wait_cnt <= next_wait_cnt;
      res      <= next_res;
      done     <= next_done;
    end
  end

  always_comb begin
    ready_o                 = (state == ST_IDLE);
    done_o                  = done;
    result_o                = res;
    status_flags_register_o = status_flags_register_i;
  end
endmodule : conditional_skip_branch_unit
`default_nettype wire

// file: testbench/csb_props.sv
`timescale 1ns/1ps
`default_nettype none
module csb_props #(parameter int PC_W = 16) (
  // watched ports
  input wire logic              sys_clk_i, rst_i, clk_en_i, issue_i, ready_o, done_o,
  input wire flow_pkg::instr_t  instr_i,
  input wire logic [PC_W-1:0]   pc_i,
  input wire logic [7:0]        io_reg_i, status_flags_register_i, status_flags_register_o,
  input wire flow_pkg::result_t result_o
);
  logic            t, io_b, fl_b, z;
  logic [2:0]      op;
  logic [PC_W-1:0] bpc, spc;
  assign op = instr_i.op;
  assign t = clk_en_i && issue_i && ready_o && op != 3'h0;
  assign io_b = io_reg_i[instr_i.bit_sel];
  assign fl_b = status_flags_register_i[instr_i.bit_sel];
  assign z = status_flags_register_i[1];
  assign bpc = pc_i + PC_W'(signed'(instr_i.offset)) + PC_W'(1);
  assign spc = pc_i + PC_W'(instr_i.next_is_two_word ? 3 : 2);
  default clocking @(posedge sys_clk_i); endclocking
  // a stalled clock enable stretches every outcome, so stalled attempts are dropped
  default disable iff (rst_i || !clk_en_i);
  property p_r1; t && op == 1 && !io_b |=> result_o.taken && result_o.pc == $past(spc); endproperty
  property p_r2; t && op == 2 && io_b |=> result_o.taken && result_o.pc == $past(spc); endproperty
  property p_r3; t && op == 3 && fl_b |=> !done_o && result_o.pc == $past(bpc) ##1 done_o; endproperty
  property p_r4; t && op == 4 && !fl_b |=> result_o.cycles == 2'h2 && result_o.pc == $past(bpc); endproperty
  property p_r5; t && op == 5 && z |=> !done_o ##1 done_o && result_o.taken; endproperty
  property p_r6; t && op == 6 && z |=> done_o && !result_o.taken && result_o.pc == $past(pc_i) + 1'b1; endproperty
  property p_r7; status_flags_register_o == status_flags_register_i; endproperty
  property p_r8; t && op < 3 && (op[0] ^ io_b) && instr_i.next_is_two_word |=> !done_o [*2] ##1 done_o; endproperty
  a_r1: assert property (p_r1) else $error("clear skip");
  a_r2: assert property (p_r2) else $error("set skip");
  a_r3: assert property (p_r3) else $error("flag set");
  a_r4: assert property (p_r4) else $error("flag clear");
  a_r5: assert property (p_r5) else $error("equal");
  a_r6: assert property (p_r6) else $error("not equal");
  a_r7: assert property (p_r7) else $error("flags");
  a_r8: assert property (p_r8) else $error("long skip");
  c_long: cover property (done_o && result_o.cycles == 2'h3);
  c_br: cover property (done_o && result_o.taken && result_o.cycles == 2'h2);
  c_no: cover property (done_o && !result_o.taken);
endmodule : csb_props
`default_nettype wire

// file: testbench/conditional_skip_branch_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module conditional_skip_branch_unit_tb;
  logic              clk = 0, rst = 1, issue = 0, ce = 1, rdy, done;
  logic [15:0]       pc = 16'hfffe;
  logic [7:0]        io = 0, sf = 0, sfo;
  flow_pkg::instr_t  ins = '0;
  flow_pkg::result_t res;
  int                n_errors = 0, comparisons = 0, cyc = 0;
  always #25 clk = ~clk;
  conditional_skip_branch_unit dut_u (.sys_clk_i(clk), .rst_i(rst), .clk_en_i(ce), .issue_i(issue),
    .instr_i(ins), .ready_o(rdy), .pc_i(pc), .io_reg_i(io), .status_flags_register_i(sf),
    .result_o(res), .done_o(done), .status_flags_register_o(sfo));
  task automatic chk(input logic [15:0] a, e);
    comparisons++;
    if (a !== e) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, a, e);
    end
  endtask : chk
  // pc fixed near the top so targets wrap
  task automatic go(input logic [2:0] o, b, input logic [6:0] k, input logic w,
                    input logic [7:0] i, f, input logic [15:0] d, input logic [1:0] c);
    logic [15:0] n;
    while (rdy !== 1'b1) @(posedge clk) #1;
    issue = 1;
    ins = '{flow_pkg::op_t'(o), b, k, w};
    io = i;
    sf = f;
    @(posedge clk) #1;
    issue = 0;
    chk(16'(rdy), 16'h0000);
    n = 1;
    while (done !== 1'b1) begin
      @(posedge clk) #1;
      n++;
    end
    chk(n, 16'(c));
    chk(16'(res.cycles), 16'(c));
    chk(res.pc, pc + d);
    chk(16'(res.taken), 16'(c > 1));
    chk(16'(sfo), 16'(f));
    @(posedge clk) #1;
    chk(16'(done), 16'h0000);
    chk(16'(rdy), 16'h0001);
  endtask : go
  // clock enable low must freeze both acceptance and a running branch
  task automatic t_hold;
    while (rdy !== 1'b1) @(posedge clk) #1;
    pc = 16'h1000;
    ce = 0;
    issue = 1;
    ins = '{flow_pkg::OP_BRANCH_IF_FLAG_SET, 3'h7, 7'h05, 1'b0};
    sf = 8'h80;
    repeat (3) @(posedge clk) #1;
    chk(16'(rdy), 16'h0001);
    chk(16'(done), 16'h0000);
    ce = 1;
    @(posedge clk) #1;
    issue = 0;
    ce = 0;
    repeat (3) @(posedge clk) #1;
    chk(16'(done), 16'h0000);
    ce = 1;
    @(posedge clk) #1;
    chk(16'(done), 16'h0001);
    chk(res.pc, 16'h1006);
    chk(16'(res.taken), 16'h0001);
    @(posedge clk) #1;
  endtask : t_hold
  task automatic t_skip;
    go(1, 3, 0, 0, 8'hf7, 0, 2, 2);
    go(1, 3, 0, 1, 8'hf7, 0, 3, 3);
    go(1, 3, 0, 1, 8'h08, 0, 1, 1);
    go(2, 5, 0, 1, 8'h20, 0, 3, 3);
    go(2, 5, 0, 0, 8'hdf, 0, 1, 1);
  endtask : t_skip
  task automatic t_flag;
    go(3, 7, 7'h3f, 0, 0, 8'h80, 16'h0040, 2);
    go(3, 7, 7'h3f, 0, 0, 8'h7f, 1, 1);
    go(4, 0, 7'h40, 0, 0, 8'hfe, 16'hffc1, 2);
    go(4, 0, 7'h40, 0, 0, 8'h01, 1, 1);
  endtask : t_flag
  task automatic t_zero;
    go(5, 0, 5, 0, 0, 8'h02, 6, 2);
    go(5, 0, 5, 0, 0, 8'hfd, 1, 1);
    go(6, 0, 5, 0, 0, 8'hfd, 6, 2);
    go(6, 0, 5, 0, 0, 8'h02, 1, 1);
  endtask : t_zero
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    t_skip();
    t_flag();
    t_zero();
    t_hold();
    give_verdict();
  end
endmodule : conditional_skip_branch_unit_tb
bind conditional_skip_branch_unit csb_props #(.PC_W(PC_W)) props_u (.*);
`default_nettype wire
